// ==== src/cmts_sequencer.sv ====
// off-line test sequencer: phase counter, start latch, flags, address count
`timescale 1ns/1ps

// What this block does
// RQ1 - phase zero auto read worst-case toggles complement
// RQ2 - phase zero counts address when enabled
// RQ3 - local mode suppresses all remote-only actions
// RQ4 - phase one always advances to two
// RQ5 - phase two parity error on manual read
// RQ6 - phase two pattern mismatch in local auto
// RQ7 - phase two always advances to three
// RQ8 - single switch gives single level, stop ready
// RQ9 - phase three remote or single returns zero
// RQ10 - continue only when no stop condition holds
// RQ11 - final address is all twelve bits set
// RQ12 - no continue halts with phase at three unless remote or single
// RQ13 - phase three sets start latch on request
// RQ14 - phase three start request drives information clear
// RQ15 - second phase-three clock relaunches timing chain
// RQ16 - phase three counts address when enabled
// RQ17 - phase three auto toggles write flag
// RQ18 - phase three worst-case toggles after reads
// RQ19 - complement flag inverts written and checked pattern
// RQ20 - normal auto: read, write, then count
// RQ21 - worst-case auto: four cycles per address
// RQ22 - start request only from local start button
// RQ23 - two-bit phase changes on step clock only
module cmts_sequencer (
  input  wire logic                        i_mclk,
  input  wire logic                        i_resetn,
  input  wire cmts_pkg::cmts_panel_t       i_panel,
  input  wire logic                        i_start_button_level,
  input  wire logic                        i_parity_fault_level,
  input  wire logic [cmts_pkg::INFO_W-1:0] i_pattern,
  input  wire logic [cmts_pkg::INFO_W-1:0] i_info_word,
  output logic      [1:0]                  o_phase_counter,
  output logic      [cmts_pkg::ADDR_W-1:0] o_address_counter,
  output logic      [cmts_pkg::INFO_W-1:0] o_write_pattern,
  output logic                             o_timing_chain_launch,
  output logic                             o_info_clear_drive,
  output cmts_pkg::cmts_status_t           o_status
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cmts_pkg::cmts_phase_t       phase_q;
  cmts_pkg::cmts_phase_t       phase_d;
  logic [cmts_pkg::ADDR_W-1:0] addr_q;
  logic [cmts_pkg::ADDR_W-1:0] addr_d;
  logic                        start_latch_q;
  logic                        start_latch_d;
  logic                        write_q;
  logic                        write_d;
  logic                        compl_q;
  logic                        compl_d;
  logic                        error_q;
  logic                        error_d;
  logic                        launch_d;
  logic                        clear_d;

  // ----------------------------------------------------------------
  // step enable and pattern compare
  // ----------------------------------------------------------------
  logic                        step;
  logic [cmts_pkg::INFO_W-1:0] expected;
  logic                        mismatch;

  cmts_step_div u_div (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .o_step   (step)
  );

  cmts_pattern u_pat (
    .i_pattern    (i_pattern),
    .i_info_word  (i_info_word),
    .i_complement (compl_q),
    .o_expected   (expected),
    .o_mismatch   (mismatch)
  );

  // ----------------------------------------------------------------
  // panel levels
  // ----------------------------------------------------------------
  logic remote_select_level;
  logic local_mode;
  logic manual_sel;
  logic manual_mode_level;
  logic auto_mode;
  logic read_cycle;
  logic start_request;
  logic single_cycle_level;
  logic final_address_detect;
  logic stop_auto_final;
  logic stop_manual_final;
  logic stop_error;
  logic continue_level;

  // the off-line sequencer never launches or clears for a remote requester
  assign remote_select_level = i_panel.remote_select_switch;  // RQ3
  assign local_mode          = ~remote_select_level;
  assign manual_sel          = i_panel.manual_select_level;
  assign manual_mode_level   = manual_sel & local_mode;
  assign auto_mode           = ~manual_sel;
  assign read_cycle          = ~write_q;

  // start button only counts while local
  assign start_request = i_start_button_level & local_mode;  // RQ22

  assign single_cycle_level = i_panel.single_cycle_select;  // RQ8

  // all six x and six y address bits at one
  assign final_address_detect =
    (addr_q == cmts_pkg::FINAL_ADDR);  // RQ11

  // ----------------------------------------------------------------
  // continue level: any stop term drops it
  // ----------------------------------------------------------------
  // end of a two or four cycle group is write set, complement clear
  assign stop_auto_final = ~compl_q & write_q & final_address_detect
                         & i_panel.stop_at_final_address;
  assign stop_manual_final = manual_mode_level & final_address_detect
                           & i_panel.stop_at_final_address;
  assign stop_error = error_q & i_panel.stop_on_error_select;
  assign continue_level = ~(remote_select_level | single_cycle_level
                          | stop_auto_final | stop_manual_final
                          | stop_error);  // RQ10

  // ----------------------------------------------------------------
  // shared decodes for the two start points (phase zero and three)
  // ----------------------------------------------------------------
  logic in_ph0;
  logic in_ph2;
  logic in_ph3;
  logic ph0_go;
  logic ph3_go;
  logic cycle_go;
  logic count_ok;
  logic addr_inc;
  logic write_tgl;
  logic compl_tgl;
  logic clear_req;
  logic err_parity;
  logic err_pattern;
  logic err_set;

  assign in_ph0 = (phase_q == cmts_pkg::PH_ZERO);
  assign in_ph2 = (phase_q == cmts_pkg::PH_TWO);
  assign in_ph3 = (phase_q == cmts_pkg::PH_THREE);

  // phase zero waits for a press; phase three reruns on the latch
  assign ph0_go = in_ph0 & start_request;
  assign ph3_go = in_ph3 & start_latch_q & ~single_cycle_level
                & local_mode;  // RQ15
  assign cycle_go = ph0_go | ph3_go;

  // counting only at the end of the address group
  assign count_ok = i_panel.count_enable_select & ~compl_q
                  & (manual_mode_level | write_q);
  assign addr_inc = cycle_go & start_latch_q & count_ok;  // RQ2 RQ16

  // automatic mode alternates read and write every cycle
  assign write_tgl = cycle_go & start_latch_q & auto_mode;  // RQ17 RQ20

  // worst case flips the complement phase after each read
  assign compl_tgl = cycle_go & start_latch_q & auto_mode & read_cycle
                   & i_panel.worst_case_pattern_select;  // RQ1 RQ18 RQ21

  // information clear on a press unless re-recording a manual write
  assign clear_req = (in_ph0 | in_ph3) & start_request
                   & (auto_mode | read_cycle);  // RQ14

  // parity matters on manual reads and on reads while remote is selected
  assign err_parity = i_parity_fault_level & read_cycle
                    & (manual_mode_level | remote_select_level);  // RQ5
  // pattern compare in local automatic operation
  assign err_pattern = mismatch & local_mode & auto_mode;  // RQ6
  assign err_set = in_ph2 & (err_parity | err_pattern);

  // ----------------------------------------------------------------
  // phase and start latch next state
  // ----------------------------------------------------------------
  always_comb begin
    phase_d       = phase_q;
    start_latch_d = start_latch_q;
    launch_d      = 1'b0;
    case (phase_q)
      cmts_pkg::PH_ZERO: begin
        if (ph0_go) begin
          launch_d      = 1'b1;
          phase_d       = cmts_pkg::PH_ONE;
          start_latch_d = 1'b0;
        end
      end
      cmts_pkg::PH_ONE: begin
        phase_d = cmts_pkg::PH_TWO;  // RQ4
      end
      cmts_pkg::PH_TWO: begin
        phase_d = cmts_pkg::PH_THREE;  // RQ7
      end
      cmts_pkg::PH_THREE: begin
        if (remote_select_level || single_cycle_level) begin
          phase_d       = cmts_pkg::PH_ZERO;  // RQ9
          start_latch_d = 1'b1;  // RQ8
        end else if (start_latch_q) begin
          launch_d      = 1'b1;  // RQ15
          phase_d       = cmts_pkg::PH_ONE;
          start_latch_d = 1'b0;
        end else if (start_request || continue_level) begin
          start_latch_d = 1'b1;  // RQ13
        end
        // otherwise no continue: hold at three until a press  RQ12
      end
      default: begin
        phase_d = cmts_pkg::PH_ZERO;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // flag and counter next values
  // ----------------------------------------------------------------
  assign addr_d  = addr_inc ? addr_q + cmts_pkg::ADDR_STEP : addr_q;
  assign write_d = write_tgl ? ~write_q : write_q;
  assign compl_d = compl_tgl ? ~compl_q : compl_q;
  assign clear_d = clear_req;
  // a fault found in the same step as a clear still sets the flag
  assign error_d = err_set ? 1'b1 : (clear_req ? 1'b0 : error_q);

  // ----------------------------------------------------------------
  // step-clock registers
  // ----------------------------------------------------------------
  // everything moves on the one-megacycle enable only
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      phase_q       <= cmts_pkg::PH_ZERO;
      start_latch_q <= 1'b0;
      addr_q        <= cmts_pkg::ADDR_RESET;
      write_q       <= 1'b0;
      compl_q       <= 1'b0;
      error_q       <= 1'b0;
    end else if (step) begin
      phase_q       <= phase_d;  // RQ23
      start_latch_q <= start_latch_d;
      addr_q        <= addr_d;
      write_q       <= write_d;
      compl_q       <= compl_d;
      error_q       <= error_d;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // strobes last one master clock, the clock after the step on which they decide;
  // the timing chain is edge triggered so a wider pulse buys nothing
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_timing_chain_launch <= 1'b0;
      o_info_clear_drive    <= 1'b0;
    end else begin
      o_timing_chain_launch <= step & launch_d;
      o_info_clear_drive    <= step & clear_d;
    end
  end

  // state mirrors, one master clock behind the flags they show
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_phase_counter   <= 2'h0;
      o_address_counter <= cmts_pkg::ADDR_RESET;
      o_write_pattern   <= '0;
      o_status          <= '0;
    end else begin
      o_phase_counter   <= phase_q;
      o_address_counter <= addr_q;
      o_write_pattern   <= expected;  // RQ19
      o_status          <= '{start_latch:           start_latch_q,
                             write_cycle_flag:      write_q,
                             complement_phase_flag: compl_q,
                             error_flag:            error_q,
                             continue_level:        continue_level,
                             final_address_detect:  final_address_detect};
    end
  end

endmodule // cmts_sequencer

// ==== src/cmts_pkg.sv ====
// constants, phase states and panel carriers for the core memory test sequencer
package cmts_pkg;

  // ----------------------------------------------------------------
  // widths and fixed values
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned INFO_W = 48;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STEP  = 12'h001;
  // octal 7777: every x and y address bit set
  localparam logic [ADDR_W-1:0] FINAL_ADDR = 12'hfff;

  // ----------------------------------------------------------------
  // timing: master clock and the one-megacycle step clock
  // ----------------------------------------------------------------
  localparam int unsigned MCLK_HZ  = 20_000_000;
  localparam int unsigned STEP_HZ  = 1_000_000;
  localparam int unsigned STEP_DIV = MCLK_HZ / STEP_HZ;
  localparam int unsigned DIV_W    = 5;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 5'h00;
  localparam logic [DIV_W-1:0] DIV_ONE  = 5'h01;

  // ----------------------------------------------------------------
  // phase counter: two bits, high bit then low bit
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_ZERO,
    PH_ONE,
    PH_TWO,
    PH_THREE
  } cmts_phase_t;

  // ----------------------------------------------------------------
  // maintenance panel switch levels, all active high
  // ----------------------------------------------------------------
  typedef struct packed {
    logic remote_select_switch;
    logic manual_select_level;
    logic worst_case_pattern_select;
    logic count_enable_select;
    logic single_cycle_select;
    logic stop_at_final_address;
    logic stop_on_error_select;
  } cmts_panel_t;

  // ----------------------------------------------------------------
  // sequencer flags shown to the panel lamps
  // ----------------------------------------------------------------
  typedef struct packed {
    logic start_latch;
    logic write_cycle_flag;
    logic complement_phase_flag;
    logic error_flag;
    logic continue_level;
    logic final_address_detect;
  } cmts_status_t;

endpackage : cmts_pkg

// ==== src/cmts_step_div.sv ====
// divider that makes the one-megacycle step enable from the master clock
`timescale 1ns/1ps

module cmts_step_div (
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  output logic      o_step
);

  // ----------------------------------------------------------------
  // modulo counter, one-cycle pulse on the last count
  // ----------------------------------------------------------------
  logic [cmts_pkg::DIV_W-1:0] cnt_q;
  logic [cmts_pkg::DIV_W-1:0] cnt_d;
  logic                       wrap;

  assign wrap  = (cnt_q == cmts_pkg::DIV_LAST);
  assign cnt_d = wrap ? cmts_pkg::DIV_ZERO : cnt_q + cmts_pkg::DIV_ONE;

  // pulse registered so the enable is glitch free
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      cnt_q  <= cmts_pkg::DIV_ZERO;
      o_step <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      o_step <= wrap;
    end
  end

endmodule // cmts_step_div

// ==== src/cmts_pattern.sv ====
// true or complement test pattern and the compare against the read word
`timescale 1ns/1ps

module cmts_pattern (
  input  wire logic [cmts_pkg::INFO_W-1:0] i_pattern,
  input  wire logic [cmts_pkg::INFO_W-1:0] i_info_word,
  input  wire logic                        i_complement,
  output logic      [cmts_pkg::INFO_W-1:0] o_expected,
  output logic                             o_mismatch
);

  // ----------------------------------------------------------------
  // per-bit selection and compare
  // ----------------------------------------------------------------
  logic [cmts_pkg::INFO_W-1:0] diff;

  // each bit inverted while the complement phase runs
  for (genvar b = 0; b < cmts_pkg::INFO_W; b++) begin : g_bit
    assign o_expected[b] = i_pattern[b] ^ i_complement;  // RQ19
    assign diff[b]       = o_expected[b] ^ i_info_word[b];
  end

  // any differing bit is a pattern error
  assign o_mismatch = |diff;

endmodule // cmts_pattern

// ==== dv/cmts_mem_model.sv ====
// far side model: the memory word read back into the info register
`timescale 1ns/1ps

module cmts_mem_model (
  input  wire logic [cmts_pkg::INFO_W-1:0] i_write_pattern,
  input  wire logic                        i_corrupt,
  output logic      [cmts_pkg::INFO_W-1:0] o_info_word
);
  // ----------------------------------------------------------------
  // stored word
  // ----------------------------------------------------------------
  // reads return the word now being written, true or complement form;
  // a forced fault flips one low bit so the compare has a miss to find
  assign o_info_word = i_corrupt ? (i_write_pattern ^ 48'h000000000001)
                                 : i_write_pattern;
endmodule // cmts_mem_model

// ==== dv/cmts_seq_monitor.sv ====
// port-level assertions for the test sequencer
`timescale 1ns/1ps

module cmts_seq_monitor (
  input wire logic                        i_mclk,
  input wire logic                        i_resetn,
  input wire cmts_pkg::cmts_panel_t       i_panel,
  input wire logic [1:0]                  o_phase_counter,
  input wire logic [cmts_pkg::ADDR_W-1:0] o_address_counter,
  input wire logic                        o_timing_chain_launch,
  input wire logic                        o_info_clear_drive,
  input wire cmts_pkg::cmts_status_t      o_status
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  // ----------------------------------------------------------------
  // phase change tracking
  // ----------------------------------------------------------------
  // gap counter saturates so a long halt cannot wrap into a false failure
  logic [1:0] ph_q;
  logic [4:0] gap_q;
  logic [4:0] gap_d;
  wire        ph_move = (ph_q != o_phase_counter);
  assign gap_d = (gap_q == 5'h1f) ? gap_q : gap_q + 5'h01;
  always_ff @(posedge i_mclk) begin
    ph_q  <= o_phase_counter;
    gap_q <= (!i_resetn || ph_move) ? 5'h00 : gap_d;
  end

  a_phase_one_two: assert property (ph_move && ph_q == 2'h1
    |-> o_phase_counter == 2'h2) else $error("phase one left wrongly");
  a_phase_two_three: assert property (ph_move && ph_q == 2'h2
    |-> o_phase_counter == 2'h3) else $error("phase two left wrongly");
  a_phase_zero_exit: assert property (ph_move && ph_q == 2'h0
    |-> o_phase_counter == 2'h1) else $error("phase zero left wrongly");
  a_phase_three_exit: assert property (ph_move && ph_q == 2'h3
    |-> o_phase_counter inside {2'h0, 2'h1}) else $error("bad exit");
  a_step_spacing: assert property (ph_move |-> gap_q >= 5'h12)
    else $error("phase moved off the step clock");
  a_launch_pulse: assert property (o_timing_chain_launch
    |=> !o_timing_chain_launch) else $error("launch too long");
  a_launch_phase: assert property (o_timing_chain_launch
    |-> ##[0:1] o_phase_counter == 2'h1) else $error("launch phase");
  a_launch_latch: assert property (o_timing_chain_launch
    |-> ##[0:2] !o_status.start_latch) else $error("latch kept");
  a_clear_pulse: assert property (o_info_clear_drive
    |=> !o_info_clear_drive) else $error("clear too long");
  a_clear_error: assert property (o_info_clear_drive
    |-> ##[0:2] !o_status.error_flag) else $error("error not cleared");
  a_remote_quiet: assert property (i_panel.remote_select_switch &&
    $past(i_panel.remote_select_switch) |-> !o_timing_chain_launch)
    else $error("launch in remote");
  a_address_step: assert property (
    o_address_counter != $past(o_address_counter) |-> o_address_counter
    == $past(o_address_counter) + cmts_pkg::ADDR_STEP)
    else $error("address moved by other than one");
endmodule // cmts_seq_monitor

bind cmts_sequencer cmts_seq_monitor u_cmts_seq_monitor (
  .i_mclk               (i_mclk),
  .i_resetn             (i_resetn),
  .i_panel              (i_panel),
  .o_phase_counter      (o_phase_counter),
  .o_address_counter    (o_address_counter),
  .o_timing_chain_launch(o_timing_chain_launch),
  .o_info_clear_drive   (o_info_clear_drive),
  .o_status             (o_status)
);

// ==== dv/testbench.sv ====
// self-checking bench for the core memory test sequencer
`timescale 1ns/1ps

module testbench;
  localparam int          LIMIT = 20000;
  localparam logic [47:0] PAT   = 48'ha5a5_0f0f_3c3c;
  logic                   i_mclk   = 1'b0;
  logic                   i_resetn = 1'b0;
  cmts_pkg::cmts_panel_t  panel    = '0;
  logic                   btn      = 1'b0;
  logic                   par      = 1'b0;
  logic                   bad      = 1'b0;
  logic [47:0]            info;
  logic [47:0]            wpat;
  logic [11:0]            addr;
  logic [1:0]             ph;
  logic                   lau;
  logic                   clr;
  cmts_pkg::cmts_status_t st;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int nl = 0;
  int nc = 0;

  always #25 i_mclk = ~i_mclk;

  cmts_sequencer u_cmts_sequencer (
    .i_mclk               (i_mclk),
    .i_resetn             (i_resetn),
    .i_panel              (panel),
    .i_start_button_level (btn),
    .i_parity_fault_level (par),
    .i_pattern            (PAT),
    .i_info_word          (info),
    .o_phase_counter      (ph),
    .o_address_counter    (addr),
    .o_write_pattern      (wpat),
    .o_timing_chain_launch(lau),
    .o_info_clear_drive   (clr),
    .o_status             (st)
  );
  cmts_mem_model u_cmts_mem_model (
    .i_write_pattern(wpat),
    .i_corrupt      (bad),
    .o_info_word    (info)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pulse counters and the hang guard; pulses stand one clock only
  always @(posedge i_mclk) begin
    cyc++;
    if (lau === 1'b1) nl++;
    if (clr === 1'b1) nc++;
    if (cyc == LIMIT) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d, mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(negedge i_mclk);
    i_resetn = 1'b0;
    repeat (10) @(negedge i_mclk);
    i_resetn = 1'b1;
    @(negedge i_mclk);
  endtask

  // bounded waits; a miss shows up as a failed compare
  task automatic wait_ph(input logic [1:0] p);
    int k;
    k = 0;
    while (ph !== p && k < 200) begin
      @(negedge i_mclk);
      k++;
    end
    check(48'(ph), 48'(p));
  endtask

  task automatic wait_lau(input int n);
    int k;
    int goal;
    k = 0;
    goal = nl + n;
    while (nl < goal && k < 2000) begin
      @(negedge i_mclk);
      k++;
    end
    check(48'(nl), 48'(goal));
  endtask

  // button held until the launch is seen, so it spans a step edge
  task automatic press();
    btn = 1'b1;
    wait_lau(1);
    btn = 1'b0;
  endtask

  task automatic single_cycle();
    press();
    wait_ph(2'h3);
    wait_ph(2'h0);
    repeat (3) @(negedge i_mclk);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    check(48'(ph), 48'h0);
    check(48'(st), 48'h2);
    repeat (60) @(negedge i_mclk);
    check(48'(nl), 48'h0);
    $display("test reset done");
    panel.manual_select_level = 1'b1;
    panel.count_enable_select = 1'b1;
    panel.single_cycle_select = 1'b1;
    single_cycle();
    check(48'(st.start_latch), 48'h1);
    check(48'(addr), 48'h0);
    check(48'(nc), 48'h1);
    par = 1'b1;
    single_cycle();
    par = 1'b0;
    check(48'(addr), 48'h1);
    check(48'(st.error_flag), 48'h1);
    single_cycle();
    check(48'(st.error_flag), 48'h0);
    check(48'(addr), 48'h2);
    $display("test manual single done");
    panel.remote_select_switch = 1'b1;
    btn = 1'b1;
    repeat (60) @(negedge i_mclk);
    btn = 1'b0;
    check(48'(nl), 48'h3);
    check(48'(ph), 48'h0);
    $display("test remote done");
    do_reset();
    panel = '0;
    panel.count_enable_select = 1'b1;
    press();
    wait_lau(6);
    repeat (3) @(negedge i_mclk);
    check(48'(addr), 48'h3);
    check(48'(st.write_cycle_flag), 48'h0);
    check(wpat, PAT);
    panel.stop_on_error_select = 1'b1;
    bad = 1'b1;
    repeat (300) @(negedge i_mclk);
    check(48'(ph), 48'h3);
    check(48'(st.error_flag), 48'h1);
    check(48'(st.continue_level), 48'h0);
    bad = 1'b0;
    panel.stop_on_error_select = 1'b0;
    wait_lau(1);
    $display("test auto normal done");
    do_reset();
    panel.worst_case_pattern_select = 1'b1;
    press();
    wait_lau(1);
    repeat (3) @(negedge i_mclk);
    check(48'(st.complement_phase_flag), 48'h1);
    check(wpat, ~PAT);
    wait_lau(7);
    repeat (3) @(negedge i_mclk);
    check(48'(addr), 48'h2);
    check(48'(st.complement_phase_flag), 48'h0);
    $display("test auto worst done");
    do_reset();
    panel.single_cycle_select = 1'b1;
    single_cycle();
    single_cycle();
    check(48'(st.complement_phase_flag), 48'h1);
    check(48'(st.write_cycle_flag), 48'h1);
    $display("test auto single done");
    print_verdict();
  end
endmodule // testbench
